/* File: verification/smtg_guard_tb_top.sv */
// self-checking bench for the bus timing and timeout guard
`timescale 1ns/1ps
module smtg_guard_tb_top;
  import smtg_pkg::*;
  localparam int TOUT = 2000;
  localparam int SEXT = 1500;
  localparam int MEXT = 800;
  localparam int OFF  = 3000;
  localparam int RDY  = 200;
  logic clk, lclk, rstn, scl, sda, scl_o, sda_o, scl_oe, sda_oe, h_scl, h_sda;
  logic mreq, mhold, mrs, mstop, shold, busy, inmsg, bidle;
  logic tout, irst, sspent, mspent, boff, brdy;
  int   num_errors, samples_checked, seed, n, a, k;
  // ----------------------------------------
  // clocks and pulled-up open-drain wires
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  assign scl = ~(scl_oe | h_scl);
  assign sda = ~(sda_oe | h_sda);
  smtg_guard #(.TOUT_CYC(TOUT), .SEXT_CYC(SEXT), .MEXT_CYC(MEXT), .OFF_CYC(OFF),
    .RDY_CYC(RDY)) dut_u (.CLK(clk), .RSTN(rstn), .LCLK(lclk), .SCL_IN(scl),
    .SDA_IN(sda), .SCL_OUT(scl_o), .SCL_OE(scl_oe), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
    .MST_REQ(mreq), .MST_HOLD(mhold), .MST_RSTART(mrs), .MST_STOP(mstop),
    .SLV_HOLD(shold), .MST_BUSY(busy), .IN_MSG(inmsg), .BUS_IDLE(bidle),
    .TIMEOUT(tout), .IDLE_RESET(irst), .SEXT_SPENT(sspent), .MEXT_SPENT(mspent),
    .BUS_OFF(boff), .BUS_READY(brdy));
  smtg_host_model host_u (.clk(clk), .scl(scl), .scl_pull(h_scl), .sda_pull(h_sda));
  // ----------------------------------------
  // compare, wait and report
  // ----------------------------------------
  task automatic chk(input string nm, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // integer model window: the count must lie within lo..hi cycles
  task automatic rng(input string nm, input int v, input int lo, input int hi);
    chk(nm, v >= lo && v <= hi, 1'b1);
  endtask
  function automatic logic sel(input int i);
    case (i)
      0: return tout;
      1: return irst;
      2: return sspent;
      3: return mspent;
      4: return boff;
      5: return brdy;
      6: return scl_oe;
      7: return sda_oe;
      default: return busy;
    endcase
  endfunction
  // bounded wait; a run-out leaves cnt at lim, which no window accepts
  task automatic wl(input int i, input logic lv, input int lim, output int cnt);
    cnt = 0;
    while (sel(i) !== lv && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {rstn, mreq, mhold, mrs, mstop, shold} = 6'h00;
    num_errors = 0;
    samples_checked = 0;
    seed = 56;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    wl(5, 1'b1, RDY + 40, n);
    rng("ready", n, RDY, RDY + 12);
    done("reset");
    host_u.start_msg();
    k = 2 + ($unsigned($random(seed)) % 4);
    a = 50 + ($unsigned($random(seed)) % 350);
    repeat (k) host_u.pulse(a);
    chk("in_msg", inmsg, 1'b1);
    host_u.idle(a);
    host_u.scl_pull <= 1'b0;
    wl(1, 1'b1, 600, n);
    rng("idle_rst", n, 500, 512);
    @(negedge clk);
    chk("idle_msg", inmsg, 1'b0);
    chk("bus_idle", bidle, 1'b1);
    host_u.sda_pull <= 1'b0;
    done("idle");
    host_u.start_msg();
    wl(0, 1'b1, TOUT + 100, n);
    rng("timeout", n, TOUT, TOUT + 12);
    @(negedge clk);
    chk("tout_msg", inmsg, 1'b0);
    host_u.stop_msg();
    done("timeout");
    host_u.start_msg();
    shold <= 1'b1;
    host_u.idle(20);
    host_u.scl_pull <= 1'b0;
    host_u.idle(20);
    chk("s_hold", scl_oe, 1'b1);
    wl(2, 1'b1, SEXT + 100, n);
    rng("s_budget", n + 40, SEXT, SEXT + 15);
    repeat (2) @(negedge clk);
    chk("s_free", scl_oe, 1'b0);
    shold <= 1'b0;
    host_u.stop_msg();
    done("slave");
    host_u.idle(60);
    mreq <= 1'b1;
    wl(7, 1'b1, 200, a);
    rng("t_free", a, 47, 60);
    mreq <= 1'b0;
    wl(6, 1'b1, 100, n);
    rng("t_hold", n, 40, 46);
    wl(6, 1'b0, 300, a);
    wl(6, 1'b1, 300, n);
    rng("period", a + n, 190, 212);
    mrs <= 1'b1;
    wl(6, 1'b0, 300, n);
    wl(7, 1'b1, 300, a);
    rng("t_rsu", a, 47, 60);
    mrs <= 1'b0;
    wl(6, 1'b1, 100, n);
    mhold <= 1'b1;
    wl(3, 1'b1, MEXT + 300, n);
    rng("m_budget", n, MEXT, MEXT + 110);
    mhold <= 1'b0;
    mstop <= 1'b1;
    wl(6, 1'b0, 300, n);
    wl(7, 1'b0, 300, a);
    rng("t_stop", a, 40, 52);
    wl(8, 1'b0, 20, n);
    chk("m_busy", busy, 1'b0);
    chk("scl_out", scl_o, 1'b0);
    chk("sda_out", sda_o, 1'b0);
    mstop <= 1'b0;
    done("master");
    shold <= 1'b1;
    host_u.idle(10);
    chk("s_refuse", scl_oe, 1'b0);
    shold <= 1'b0;
    host_u.idle(100);
    host_u.scl_pull <= 1'b1;
    host_u.idle(1);
    host_u.sda_pull <= 1'b1;
    wl(4, 1'b1, OFF + 100, n);
    rng("bus_off", n, OFF, OFF + 12);
    @(negedge clk);
    chk("off_rdy", brdy, 1'b0);
    host_u.sda_pull <= 1'b0;
    wl(4, 1'b0, 20, n);
    rng("off_exit", n, 1, 12);
    wl(5, 1'b1, RDY + 40, n);
    rng("re_ready", n, RDY, RDY + 12);
    host_u.scl_pull <= 1'b0;
    done("bus_off");
    end_of_test();
  end
endmodule

/* File: verification/smtg_host_model.sv */
// host controller model: open-drain pulls on the bus clock and data lines
`timescale 1ns/1ps
module smtg_host_model (
  // clock
  input  wire logic  clk,
  // bus clock level
  input  wire logic  scl,
  // pulls, high = line held low
  output logic       scl_pull,
  output logic       sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ----------------------------------------
  // frame pieces, clock stands still between them
  // ----------------------------------------
  task automatic start_msg();
    idle(50);
    sda_pull <= 1'b1;
    idle(45);
    scl_pull <= 1'b1;
  endtask
  // also the acknowledge pulse; a stretched clock is waited out, bounded
  task automatic pulse(input int half);
    int k;
    k = 0;
    idle(half);
    scl_pull <= 1'b0;
    idle(1);
    while (scl !== 1'b1 && k < 4000) begin
      idle(1);
      k++;
    end
    idle(half);
    scl_pull <= 1'b1;
  endtask
  task automatic stop_msg();
    scl_pull <= 1'b1;
    sda_pull <= 1'b1;
    idle(50);
    scl_pull <= 1'b0;
    idle(45);
    sda_pull <= 1'b0;
  endtask
endmodule

/* File: verilog/smtg_guard.sv */
// bus timing, timeout, stretch budget and bus-off supervision
// ----------------------------------------
// Overview of operation
// [RL1] host slave-mode clock stays 10 to 100 kHz
// [RL2] master clock runs at nominal 51.2 kHz
// [RL3] clock low past 25 ms aborts as timeout
// [RL4] clock high over 50 us resets transaction
// [RL5] slave stretching capped at 25 ms per message
// [RL6] master stretching capped at 10 ms per message
// [RL7] bus free 4.7 us between stop and start
// [RL8] clock high 4 us after start
// [RL9] clock high 4.7 us before repeated start
// [RL10] master supplies the acknowledge clock pulse
// [RL11] both lines low 2 s enters bus-off
// [RL12] either line high leaves bus-off, ready within 1 ms
// [RL13] all timing from counters on the internal clock
// ----------------------------------------
`timescale 1ns/1ps
`include "smtg_map.svh"
module smtg_guard
  import smtg_pkg::*;
#(
  parameter int TOUT_CYC = `SMTG_TOUT_MS * `SMTG_CLK_MHZ * 1000,
  parameter int SEXT_CYC = `SMTG_SEXT_MS * `SMTG_CLK_MHZ * 1000,
  parameter int MEXT_CYC = `SMTG_MEXT_MS * `SMTG_CLK_MHZ * 1000,
  parameter int OFF_CYC  = `SMTG_OFF_MS * `SMTG_CLK_MHZ * 1000,
  parameter int RDY_CYC  = `SMTG_RDY_MS * `SMTG_CLK_MHZ * 1000
)(
  // clocks and reset
  input  wire logic  CLK,
  input  wire logic  RSTN,
  input  wire logic  LCLK,
  // bus pins, open drain
  input  wire logic  SCL_IN,
  input  wire logic  SDA_IN,
  output logic       SCL_OUT,
  output logic       SCL_OE,
  output logic       SDA_OUT,
  output logic       SDA_OE,
  // requests from the device core
  input  wire logic  MST_REQ,
  input  wire logic  MST_HOLD,
  input  wire logic  MST_RSTART,
  input  wire logic  MST_STOP,
  input  wire logic  SLV_HOLD,
  // status to the device core
  output logic       MST_BUSY,
  output logic       IN_MSG,
  output logic       BUS_IDLE,
  output logic       TIMEOUT,
  output logic       IDLE_RESET,
  output logic       SEXT_SPENT,
  output logic       MEXT_SPENT,
  output logic       BUS_OFF,
  output logic       BUS_READY
);
  localparam int CW = `SMTG_CW;
  localparam int MHZ = `SMTG_CLK_MHZ;
  // least times round up, longest times round down
  localparam logic [CW-1:0] K_BUF   = CW'((`SMTG_TBUF_NS * MHZ + 999) / 1000);
  localparam logic [CW-1:0] K_HDSTA = CW'((`SMTG_THDSTA_NS * MHZ + 999) / 1000);
  localparam logic [CW-1:0] K_SUSTA = CW'((`SMTG_TSUSTA_NS * MHZ + 999) / 1000);
  localparam logic [CW-1:0] K_SUSTO = CW'((`SMTG_TSUSTO_NS * MHZ + 999) / 1000);
  localparam logic [CW-1:0] K_IDLE  = CW'(`SMTG_THIGH_US * MHZ);
  localparam logic [CW-1:0] K_HALF  = CW'(MHZ * 10000000 / (2 * `SMTG_MAS_HZ_X10));
  localparam logic [CW-1:0] K_TOUT  = CW'(TOUT_CYC);
  localparam logic [CW-1:0] K_SEXT  = CW'(SEXT_CYC);
  localparam logic [CW-1:0] K_MEXT  = CW'(MEXT_CYC);
  localparam logic [CW-1:0] K_OFF   = CW'(OFF_CYC);
  localparam logic [CW-1:0] K_RDY   = CW'(RDY_CYC);
  // ----------------------------------------
  // reset release and link monitor
  // ----------------------------------------
  logic [1:0]  rst_q;
  logic        rst_n;
  smtg_state_t s;
  smtg_state_t next_s;
  logic        scl;
  logic        sda;
  logic        start_ev;
  logic        stop_ev;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];
  smtg_link_if lk ();
  smtg_link_mon u_mon (
    .lclk    (LCLK),
    .rst_n   (rst_n),
    .scl_pin (SCL_IN),
    .sda_pin (SDA_IN),
    .lk      (lk.mon)
  );
  assign scl      = s.scl_m2;
  assign sda      = s.sda_m2;
  assign start_ev = s.st_m2 ^ s.st_m3;
  assign stop_ev  = s.sp_m2 ^ s.sp_m3;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s          = s;
    {next_s.scl_m2, next_s.scl_m1} = {s.scl_m1, lk.scl};
    {next_s.sda_m2, next_s.sda_m1} = {s.sda_m1, lk.sda};
    {next_s.st_m3, next_s.st_m2, next_s.st_m1} = {s.st_m2, s.st_m1, lk.start_tgl};
    {next_s.sp_m3, next_s.sp_m2, next_s.sp_m1} = {s.sp_m2, s.sp_m1, lk.stop_tgl};
    next_s.timeout  = 1'b0;
    next_s.idle_rst = 1'b0;
    // low and high watchdogs, saturating [RL13]
    if (!scl) begin
      next_s.high_cnt = '0;
      next_s.bus_idle = 1'b0;
      if (s.low_cnt != K_TOUT) next_s.low_cnt = s.low_cnt + 1'b1;
      if (s.low_cnt == K_TOUT - 1'b1) next_s.timeout = 1'b1; // [RL3]
    end else begin
      next_s.low_cnt = '0;
      if (s.high_cnt != K_IDLE) next_s.high_cnt = s.high_cnt + 1'b1;
      // a legal slave-mode clock never stays high this long [RL1]
      if (s.high_cnt == K_IDLE - 1'b1) begin
        next_s.idle_rst = 1'b1; // [RL4]
        next_s.bus_idle = 1'b1;
      end
    end
    if (stop_ev || next_s.timeout || next_s.idle_rst) next_s.in_msg = 1'b0;
    // a start wins over a same-cycle clear; budgets restart only on the first start
    if (start_ev) begin
      if (!s.in_msg) begin
        next_s.sext     = '0;
        next_s.mext     = '0;
        next_s.sext_out = 1'b0;
        next_s.mext_out = 1'b0;
      end
      next_s.in_msg   = 1'b1;
      next_s.bus_idle = 1'b0;
    end
    // bus-off supervision
    if (!scl && !sda) begin
      if (s.off_cnt != K_OFF) next_s.off_cnt = s.off_cnt + 1'b1;
      if (s.off_cnt == K_OFF - 1'b1) begin
        next_s.bus_off = 1'b1; // [RL11]
        next_s.ready   = 1'b0;
      end
    end else begin
      next_s.off_cnt = '0;
      if (s.bus_off) begin
        next_s.bus_off = 1'b0; // [RL12]
        next_s.rdy_cnt = '0;
      end
    end
    if (!s.bus_off && !s.ready) begin
      next_s.rdy_cnt = s.rdy_cnt + 1'b1;
      if (s.rdy_cnt == K_RDY - 1'b1) next_s.ready = 1'b1; // [RL12]
    end
    // master sequencer
    case (s.mst)
      M_IDLE: begin
        next_s.sda_oe = 1'b0;
        // slave stretch: only grab a clock that is already low
        next_s.scl_oe = SLV_HOLD && s.in_msg && !s.sext_out && (!scl || s.scl_oe);
        if (s.scl_oe) begin
          if (s.sext != K_SEXT) next_s.sext = s.sext + 1'b1;
          if (s.sext == K_SEXT - 1'b1) begin
            next_s.sext_out = 1'b1; // [RL5]
            next_s.scl_oe   = 1'b0;
          end
        end
        if (MST_REQ && s.ready && !s.in_msg && !next_s.scl_oe) begin
          next_s.mst = M_FREE;
          next_s.tmr = '0;
        end
      end
      M_FREE: begin
        next_s.tmr = (!scl || !sda || s.in_msg) ? '0 : s.tmr + 1'b1;
        if (scl && sda && !s.in_msg && s.tmr == K_BUF - 1'b1) begin
          next_s.sda_oe = 1'b1; // [RL7]
          next_s.tmr    = '0;
          next_s.mst    = M_HOLD;
        end
      end
      M_HOLD: begin
        next_s.tmr = s.tmr + 1'b1;
        if (s.tmr == K_HDSTA - 1'b1) begin
          next_s.scl_oe = 1'b1; // [RL8]
          next_s.sda_oe = 1'b0;
          next_s.tmr    = '0;
          next_s.mst    = M_LOW;
        end
      end
      M_LOW: begin
        if (s.tmr != K_HALF - 1'b1) begin
          next_s.tmr = s.tmr + 1'b1;
        end else if (MST_HOLD && !s.mext_out) begin
          if (s.mext != K_MEXT) next_s.mext = s.mext + 1'b1;
          if (s.mext == K_MEXT - 1'b1) next_s.mext_out = 1'b1; // [RL6]
        end else begin
          next_s.tmr    = '0;
          next_s.scl_oe = 1'b0;
          if (MST_STOP) begin
            next_s.sda_oe = 1'b1;
            next_s.mst    = M_STOP;
          end else if (MST_RSTART) begin
            next_s.mst = M_RSU;
          end else begin
            next_s.mst = M_HIGH;
          end
        end
      end
      M_HIGH: begin
        // every high phase, ack included, is ours to make [RL10]
        next_s.tmr = !scl ? '0 : s.tmr + 1'b1;
        if (scl && s.tmr == K_HALF - 1'b1) begin
          next_s.scl_oe = 1'b1; // [RL2]
          next_s.tmr    = '0;
          next_s.mst    = M_LOW;
        end
      end
      M_RSU: begin
        next_s.tmr = (!scl || !sda) ? '0 : s.tmr + 1'b1;
        if (scl && sda && s.tmr == K_SUSTA - 1'b1) begin
          next_s.sda_oe = 1'b1; // [RL9]
          next_s.tmr    = '0;
          next_s.mst    = M_HOLD;
        end
      end
      M_STOP: begin
        next_s.tmr = !scl ? '0 : s.tmr + 1'b1;
        if (scl && s.tmr == K_SUSTO - 1'b1) begin
          next_s.sda_oe = 1'b0;
          next_s.mst    = M_IDLE;
        end
      end
      default: next_s.mst = M_IDLE;
    endcase
    // abandon everything on timeout or bus-off
    if (next_s.timeout || s.bus_off) begin
      next_s.mst    = M_IDLE; // [RL3]
      next_s.scl_oe = 1'b0;
      next_s.sda_oe = 1'b0;
    end
    next_s.ms_busy = (next_s.mst != M_IDLE);
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SCL_OUT    = s.scl_o;
  assign SCL_OE     = s.scl_oe;
  assign SDA_OUT    = s.sda_o;
  assign SDA_OE     = s.sda_oe;
  assign MST_BUSY   = s.ms_busy;
  assign IN_MSG     = s.in_msg;
  assign BUS_IDLE   = s.bus_idle;
  assign TIMEOUT    = s.timeout;
  assign IDLE_RESET = s.idle_rst;
  assign SEXT_SPENT = s.sext_out;
  assign MEXT_SPENT = s.mext_out;
  assign BUS_OFF    = s.bus_off;
  assign BUS_READY  = s.ready;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);
  sequence s_hold_end;  $past(s.mst) == M_HOLD && s.mst == M_LOW;  endsequence
  sequence s_free_end;  $past(s.mst) == M_FREE && s.mst == M_HOLD; endsequence
  sequence s_rsu_end;   $past(s.mst) == M_RSU && s.mst == M_HOLD;  endsequence
  sequence s_high_end;  $past(s.mst) == M_HIGH && s.mst == M_LOW;  endsequence
  low_timeout_a: assert property (!scl && s.low_cnt == K_TOUT - 1'b1 |=> s.timeout) // [RL3]
    else $error("clock low past limit without timeout");
  abort_release_a: assert property (s.timeout |-> s.mst == M_IDLE && !s.scl_oe && !s.in_msg) // [RL3]
    else $error("timeout did not abandon the transfer");
  idle_reset_a: assert property (scl && !start_ev && s.high_cnt == K_IDLE - 1'b1 // [RL4]
    |=> s.idle_rst && !s.in_msg) else $error("long clock high did not reset transaction");
  slave_budget_a: assert property (s.sext_out && s.mst == M_IDLE |=> !s.scl_oe) // [RL5]
    else $error("slave stretch beyond budget");
  master_budget_a: assert property (s.mext_out && s.mst == M_LOW && s.tmr == K_HALF - 1'b1 // [RL6]
    |=> !s.scl_oe) else $error("master stretch beyond budget");
  bus_free_a: assert property (s_free_end |-> $past(s.tmr) == K_BUF - 1'b1 && s.sda_oe) // [RL7]
    else $error("start issued before bus free time");
  start_hold_a: assert property (s_hold_end |-> $past(s.tmr) == K_HDSTA - 1'b1 && s.scl_oe) // [RL8]
    else $error("clock pulled low too soon after start");
  rstart_setup_a: assert property (s_rsu_end |-> $past(s.tmr) == K_SUSTA - 1'b1) // [RL9]
    else $error("repeated start setup too short");
  half_period_a: assert property (s_high_end |-> $past(s.tmr) == K_HALF - 1'b1) // [RL2]
    else $error("master clock high phase wrong length");
  bus_off_a: assert property (!scl && !sda && s.off_cnt == K_OFF - 1'b1 |=> s.bus_off) // [RL11]
    else $error("bus-off not entered");
  bus_on_a: assert property (s.bus_off && (scl || sda) |=> !s.bus_off && !s.ready) // [RL12]
    else $error("bus-off not left on line high");
  ready_wait_a: assert property (!s.bus_off && !s.ready |-> s.rdy_cnt < K_RDY) // [RL12]
    else $error("ready delay overran");
endmodule

/* File: verilog/smtg_link_if.sv */
// link-side bus observations passed to the timing core
`timescale 1ns/1ps
interface smtg_link_if;
  logic scl;
  logic sda;
  logic start_tgl;
  logic stop_tgl;
  modport mon  (output scl, output sda, output start_tgl, output stop_tgl);
  modport core (input scl, input sda, input start_tgl, input stop_tgl);
endinterface

/* File: verilog/smtg_link_mon.sv */
// bus line monitor on the link clock: synchronisers and start/stop detect
`timescale 1ns/1ps
module smtg_link_mon
  import smtg_pkg::*;
(
  // clock and reset
  input  wire logic  lclk,
  input  wire logic  rst_n,
  // bus pins
  input  wire logic  scl_pin,
  input  wire logic  sda_pin,
  // to the core
  smtg_link_if.mon   lk
);
  smtg_lnk_t s;
  smtg_lnk_t next_s;

  always_comb begin
    next_s      = s;
    next_s.scl1 = scl_pin;
    next_s.scl2 = s.scl1;
    next_s.scl3 = s.scl2;
    next_s.sda1 = sda_pin;
    next_s.sda2 = s.sda1;
    next_s.sda3 = s.sda2;
    // start: data falls while clock high; stop: data rises while clock high
    if (s.scl2 && s.scl3 && s.sda3 && !s.sda2) begin
      next_s.st = ~s.st;
    end
    if (s.scl2 && s.scl3 && !s.sda3 && s.sda2) begin
      next_s.sp = ~s.sp;
    end
  end

  always_ff @(posedge lclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // events leave as toggles so the slower clock cannot miss them
  assign lk.scl       = s.scl2;
  assign lk.sda       = s.sda2;
  assign lk.start_tgl = s.st;
  assign lk.stop_tgl  = s.sp;
endmodule

/* File: verilog/smtg_map.svh */
// timing constants of the bus timing and timeout guard
`ifndef SMTG_MAP_SVH
`define SMTG_MAP_SVH

// ----------------------------------------
// counter width and clock rate
// ----------------------------------------
`define SMTG_CW          25
`define SMTG_CLK_MHZ     10

// ----------------------------------------
// bus times in their own units
// ----------------------------------------
`define SMTG_MAS_HZ_X10  512000
`define SMTG_TOUT_MS     25
`define SMTG_THIGH_US    50
`define SMTG_SEXT_MS     25
`define SMTG_MEXT_MS     10
`define SMTG_TBUF_NS     4700
`define SMTG_THDSTA_NS   4000
`define SMTG_TSUSTA_NS   4700
`define SMTG_TSUSTO_NS   4000
`define SMTG_OFF_MS      2000
`define SMTG_RDY_MS      1

`endif

/* File: verilog/smtg_pkg.sv */
// types of the bus timing and timeout guard
`include "smtg_map.svh"
package smtg_pkg;
  typedef enum logic [2:0] {
    M_IDLE, M_FREE, M_HOLD, M_LOW, M_HIGH, M_RSU, M_STOP
  } smtg_mst_t;

  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3, st, sp;
  } smtg_lnk_t;

  typedef struct packed {
    logic                 scl_m1, scl_m2, sda_m1, sda_m2;
    logic                 st_m1, st_m2, st_m3, sp_m1, sp_m2, sp_m3;
    smtg_mst_t            mst;
    logic [`SMTG_CW-1:0]  tmr, low_cnt, high_cnt, off_cnt, rdy_cnt, sext, mext;
    logic                 in_msg, bus_idle, bus_off, ready, timeout, idle_rst;
    logic                 sext_out, mext_out, ms_busy;
    logic                 scl_oe, sda_oe, scl_o, sda_o;
  } smtg_state_t;
endpackage
